// file: logic/fesr_ctrl.sv
// Erase, suspend and resume controller of a serial NOR flash, register model.
// Assumes an AXI4-Lite master on clk, and a link clock sampled as a plain input.
// Notes on behaviour
// - Chip erase runs only with protect bits zero.
// - Chip erase skips locked sectors without error.
// - Lock erase sets bits, aborts when protected.
// - Erase check reports last erase completion.
// - Erase check needs no enable, drives busy.
// - Count load fills 23-bit count, busy meanwhile.
// - Count bit 23 flags corrupted reset count.
// - Suspend halts operation; busy shows stop.
// - Program suspend only while programming; flag shows.
// - Reads in suspended page are undefined.
// - Erase suspend only for sector erase.
// - Erase suspended flag shows suspend until resume.
// - Program during erase suspend returns there.
// - New erase ignored while anything suspended.
// - Clear after failed program keeps erase suspended.
// - Reads in suspended sector are undefined.
// - Check suspend only during check, within time.
// - Resume program first, then erase, then check, else ignore.
// - Status one reads accepted during any suspend.
// - Erase needs enable; completion clears enable.
`timescale 1ns/1ns
`include "fesr_defs.svh"
module fesr_ctrl #(
	parameter int unsigned OP_CYCLES = `FESR_OPS_NS / `FESR_CLK_NS
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Link clock from the host, sampled.
	input  wire logic        linkClk,
	// AXI4-Lite write address and data.
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response.
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Status flags for direct observation.
	output logic             deviceBusy,
	output logic             undefinedRead
);
	localparam int unsigned EES_CYC  = (`FESR_EES_NS + `FESR_CLK_NS - 1) / `FESR_CLK_NS;
	localparam int unsigned SEC_CYC  = (`FESR_SEC_NS + `FESR_CLK_NS - 1) / `FESR_CLK_NS;
	localparam int          PEDS_CYC = `FESR_PEDS_NS / `FESR_CLK_NS;

	if (OP_CYCLES < 2) begin : gBadCycles
		$error("OP_CYCLES must be at least two.");
	end

	fesr_pkg::fesr_state_s st;
	fesr_pkg::fesr_state_s next_st;
	logic                  wrFire;
	logic                  running;
	logic                  anySus;
	logic [3:0]            opc;
	logic [31:0]           s1;
	logic [31:0]           rdVal;
	logic [15:0]           readSector;
	logic [15:0]           readPage;
	logic [2:0]            protBits;

	assign wrFire     = st.awOk && st.wOk && !st.bValid;
	assign opc        = st.wData[3:0];
	assign running    = st.op != fesr_pkg::FESR_IDLE;
	assign anySus     = st.progSus || st.eraseSus || st.dicSus;
	assign readSector = st.arg[`FESR_ARG_SECT];
	assign readPage   = st.arg[`FESR_ARG_PAGE];
	assign protBits   = st.prot[`FESR_PR_BP];

	always_comb begin
		s1 = '0;
		s1[`FESR_S1_BUSY]  = running;
		s1[`FESR_S1_WEN]   = st.wen;
		s1[`FESR_S1_ERR]   = st.eraseErr;
		s1[`FESR_S2_PSUS]  = st.progSus;
		s1[`FESR_S2_ESUS]  = st.eraseSus;
		s1[`FESR_S2_ESTAT] = st.eraseStat;
		s1[`FESR_S2_DSUS]  = st.dicSus;
		s1[`FESR_OX_BUSY]  = running;
		s1[`FESR_OX_ESUS]  = st.eraseSus;
		s1[`FESR_OX_PSUS]  = st.progSus;
		s1[`FESR_OX_DSUS]  = st.dicSus;
	end

	always_comb begin
		case (s_axi_araddr)
		`FESR_A_STAT:  rdVal = s1;
		`FESR_A_PROT:  rdVal = {23'h0, st.ppbAllOnes, st.prot};
		`FESR_A_COUNT: rdVal = {8'h0, st.count};
		`FESR_A_ARG:   rdVal = st.arg;
		`FESR_A_RDCHK: rdVal = {15'h0, (st.eraseSus && readSector == st.eraseSector) ||
		                       (st.progSus && readPage == st.progPage), st.sclkEdges};
		default:       rdVal = 32'h0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.sclkSync = {st.sclkSync[1:0], linkClk};
		if (st.sclkSync[2] == st.sclkSync[1] && st.sclkSync[1] != st.sclkSeen) begin
			next_st.sclkSeen  = st.sclkSync[1];
			next_st.sclkEdges = st.sclkEdges + 16'h1;
		end
		if (s_axi_awvalid && !st.awOk) begin
			next_st.awOk   = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.wOk) begin
			next_st.wOk   = 1'b1;
			next_st.wData = s_axi_wdata;
		end
		if (st.bValid && s_axi_bready) begin
			next_st.bValid = 1'b0;
		end
		if (st.rValid && s_axi_rready) begin
			next_st.rValid  = 1'b0;
			next_st.arReady = 1'b1;
		end else if (s_axi_arvalid && st.arReady) begin
			next_st.arReady = 1'b0;
			next_st.rValid  = 1'b1;
			next_st.rData   = rdVal;
			next_st.rResp   = (s_axi_araddr > `FESR_A_RDCHK || s_axi_araddr[1:0] != 2'h0) ?
			                  2'h2 : 2'h0;
		end
		if (running) begin
			if (st.timer != 32'h0) begin
				next_st.timer = st.timer - 32'h1;
			end else begin
				next_st.op = fesr_pkg::FESR_IDLE;
				case (st.op)
				fesr_pkg::FESR_SECT, fesr_pkg::FESR_CHIP: begin
					next_st.wen       = 1'b0;
					next_st.eraseStat = 1'b1;
				end
				fesr_pkg::FESR_PROG: begin
					next_st.wen = 1'b0;
					next_st.eraseSus = st.progInErase;
					next_st.progInErase = 1'b0;
				end
				fesr_pkg::FESR_EVAL: begin
					next_st.eraseStat = st.eraseSector == st.arg[31:16] &&
					                    !st.eraseSus;
				end
				fesr_pkg::FESR_CNT: begin
					next_st.count = {st.count[22:0] == 23'h7fffff,
					                 st.count[22:0] + 23'h1};
				end
				default: begin
					next_st.op = fesr_pkg::FESR_IDLE;
				end
				endcase
			end
		end
		if (wrFire) begin
			next_st.awOk   = 1'b0;
			next_st.wOk    = 1'b0;
			next_st.bValid = 1'b1;
			next_st.bResp  = (st.awAddr > `FESR_A_RDCHK || st.awAddr[1:0] != 2'h0) ?
			                 2'h2 : 2'h0;
			case (st.awAddr)
			`FESR_A_PROT: next_st.prot = st.wData[7:0];
			`FESR_A_ARG:  next_st.arg  = st.wData;
			`FESR_A_CMD: begin
				case (opc)
				`FESR_OP_WREN: begin
					if (!running) begin
						next_st.wen = 1'b1;
					end
				end
				`FESR_OP_CHIP: begin
					if (!running && !anySus && st.wen) begin
						if (protBits == 3'h0) begin
							next_st.op    = fesr_pkg::FESR_CHIP;
							next_st.timer = OP_CYCLES;
						end else begin
							next_st.wen = 1'b0;
						end
					end
				end
				`FESR_OP_SECT: begin
					if (!running && !anySus && st.wen) begin
						next_st.op          = fesr_pkg::FESR_SECT;
						next_st.timer       = OP_CYCLES;
						next_st.eraseSector = st.arg[31:16];
						next_st.eraseStat   = 1'b0;
					end
				end
				`FESR_OP_PROG: begin
					if (!running && !st.progSus && !st.dicSus && st.wen) begin
						next_st.op          = fesr_pkg::FESR_PROG;
						next_st.timer       = OP_CYCLES;
						next_st.progPage    = st.arg[23:8];
						next_st.progInErase = st.eraseSus;
					end
				end
				`FESR_OP_DIC: begin
					if (!running && !anySus) begin
						next_st.op    = fesr_pkg::FESR_DIC;
						next_st.timer = OP_CYCLES;
					end
				end
				`FESR_OP_PPBER: begin
					if (!running && st.wen) begin
						next_st.wen = 1'b0;
						if (st.prot[`FESR_PR_PLCK] || st.prot[`FESR_PR_PPMD] ||
						    st.prot[`FESR_PR_PERM]) begin
							next_st.eraseErr = 1'b1;
						end else begin
							next_st.ppbAllOnes = 1'b1;
						end
					end
				end
				`FESR_OP_EVAL: begin
					if (!running) begin
						next_st.op    = fesr_pkg::FESR_EVAL;
						next_st.timer = EES_CYC;
					end
				end
				`FESR_OP_CNT: begin
					if (!running) begin
						next_st.op    = fesr_pkg::FESR_CNT;
						next_st.timer = SEC_CYC;
					end
				end
				`FESR_OP_SUSP: begin
					case (st.op)
					fesr_pkg::FESR_PROG: begin
						next_st.op       = fesr_pkg::FESR_IDLE;
						next_st.progSus  = 1'b1;
						next_st.progLeft = st.timer;
					end
					fesr_pkg::FESR_SECT: begin
						next_st.op        = fesr_pkg::FESR_IDLE;
						next_st.eraseSus  = 1'b1;
						next_st.eraseLeft = st.timer;
					end
					fesr_pkg::FESR_DIC: begin
						next_st.op      = fesr_pkg::FESR_IDLE;
						next_st.dicSus  = 1'b1;
						next_st.dicLeft = st.timer;
					end
					default: begin
						next_st.op = st.op;
					end
					endcase
				end
				`FESR_OP_RES: begin
					if (!running) begin
						if (st.progSus) begin
							next_st.op      = fesr_pkg::FESR_PROG;
							next_st.timer   = st.progLeft;
							next_st.progSus = 1'b0;
							next_st.eraseSus = st.progInErase;
							next_st.progInErase = st.progInErase;
						end else if (st.eraseSus) begin
							next_st.op       = fesr_pkg::FESR_SECT;
							next_st.timer    = st.eraseLeft;
							next_st.eraseSus = 1'b0;
						end else if (st.dicSus) begin
							next_st.op     = fesr_pkg::FESR_DIC;
							next_st.timer  = st.dicLeft;
							next_st.dicSus = 1'b0;
						end
					end
				end
				`FESR_OP_FAIL: begin
					if (st.op == fesr_pkg::FESR_PROG) begin
						next_st.op      = fesr_pkg::FESR_IDLE;
						next_st.progErr = 1'b1;
					end
				end
				`FESR_OP_CLR: begin
					next_st.progErr  = 1'b0;
					next_st.eraseErr = 1'b0;
					next_st.eraseSus = st.eraseSus || st.progInErase;
					next_st.progInErase = 1'b0;
				end
				default: begin
					next_st.op = st.op;
				end
				endcase
			end
			default: begin
				next_st.op = st.op;
			end
			endcase
		end
		next_st.awRdy    = !next_st.awOk;
		next_st.wRdy     = !next_st.wOk;
		next_st.busyOut  = next_st.op != fesr_pkg::FESR_IDLE;
		next_st.undefOut = (next_st.eraseSus &&
		                    next_st.arg[`FESR_ARG_SECT] == next_st.eraseSector) ||
		                   (next_st.progSus &&
		                    next_st.arg[`FESR_ARG_PAGE] == next_st.progPage);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st         <= '0;
			st.op      <= fesr_pkg::FESR_IDLE;
			st.arReady <= 1'b1;
			st.awRdy   <= 1'b1;
			st.wRdy    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awRdy;
	assign s_axi_wready  = st.wRdy;
	assign s_axi_bvalid  = st.bValid;
	assign s_axi_bresp   = st.bResp;
	assign s_axi_arready = st.arReady;
	assign s_axi_rvalid  = st.rValid;
	assign s_axi_rdata   = st.rData;
	assign s_axi_rresp   = st.rResp;
	assign deviceBusy    = st.busyOut;
	assign undefinedRead = st.undefOut;

	chk_chip_prot: assert property (@(posedge clk) disable iff (!rst_n)
		wrFire && st.awAddr == `FESR_A_CMD && opc == `FESR_OP_CHIP && protBits != 3'h0
		|=> st.op != fesr_pkg::FESR_CHIP && $stable(st.eraseErr))
		else $error("Chip erase started despite protect bits.");
	chk_chip_nosus: assert property (@(posedge clk) disable iff (!rst_n)
		st.op == fesr_pkg::FESR_CHIP && st.timer != 32'h0 && wrFire &&
		st.awAddr == `FESR_A_CMD && opc == `FESR_OP_SUSP
		|=> st.op == fesr_pkg::FESR_CHIP)
		else $error("Chip erase was suspended.");
	chk_sus_halt: assert property (@(posedge clk) disable iff (!rst_n)
		st.op == fesr_pkg::FESR_PROG && wrFire && st.awAddr == `FESR_A_CMD &&
		opc == `FESR_OP_SUSP |=> !s1[`FESR_S1_BUSY] && st.progSus)
		else $error("Program suspend did not halt.");
	chk_esus_flag: assert property (@(posedge clk) disable iff (!rst_n)
		st.op == fesr_pkg::FESR_SECT && wrFire && st.awAddr == `FESR_A_CMD &&
		opc == `FESR_OP_SUSP |=> st.eraseSus && !deviceBusy)
		else $error("Erase suspend flag missing.");
	chk_no_erase: assert property (@(posedge clk) disable iff (!rst_n)
		anySus && !running |=> st.op != fesr_pkg::FESR_CHIP &&
		(st.op != fesr_pkg::FESR_SECT || $past(st.eraseSus)))
		else $error("Erase started while suspended.");
	chk_res_prog: assert property (@(posedge clk) disable iff (!rst_n)
		!running && st.progSus && wrFire && st.awAddr == `FESR_A_CMD &&
		opc == `FESR_OP_RES |=> st.op == fesr_pkg::FESR_PROG && deviceBusy)
		else $error("Resume did not restart program first.");
	chk_idle_sus: assert property (@(posedge clk) disable iff (!rst_n)
		!running && wrFire && st.awAddr == `FESR_A_CMD && opc == `FESR_OP_SUSP
		|=> $stable(st.progSus) && $stable(st.eraseSus) && $stable(st.dicSus))
		else $error("Idle suspend changed flags.");
	chk_eval_busy: assert property (@(posedge clk) disable iff (!rst_n)
		!running && wrFire && st.awAddr == `FESR_A_CMD && opc == `FESR_OP_EVAL
		|=> deviceBusy [*8])
		else $error("Erase check did not hold busy.");
	chk_wen_clear: assert property (@(posedge clk) disable iff (!rst_n)
		st.op == fesr_pkg::FESR_SECT && st.timer == 32'h0 |=> !st.wen && !deviceBusy)
		else $error("Enable not cleared after erase.");
	chk_dic_sus: assert property (@(posedge clk) disable iff (!rst_n)
		st.op == fesr_pkg::FESR_DIC && wrFire && st.awAddr == `FESR_A_CMD &&
		opc == `FESR_OP_SUSP |-> ##[1:PEDS_CYC] !deviceBusy && st.dicSus)
		else $error("Check suspend did not finish in time.");
	chk_clr_esus: assert property (@(posedge clk) disable iff (!rst_n)
		wrFire && st.awAddr == `FESR_A_CMD && opc == `FESR_OP_CLR && st.progInErase
		|=> st.eraseSus)
		else $error("Clear ended the suspended erase.");
endmodule

// file: logic/fesr_defs.svh
// Constants of the erase, suspend and resume controller.
// Assumes inclusion by the package, the controller and the bench.
`ifndef FESR_DEFS_SVH
`define FESR_DEFS_SVH
`define FESR_A_CMD      8'h00
`define FESR_A_STAT     8'h04
`define FESR_A_PROT     8'h08
`define FESR_A_COUNT    8'h0c
`define FESR_A_ARG      8'h10
`define FESR_A_RDCHK    8'h14
`define FESR_OP_WREN    4'h1
`define FESR_OP_CHIP    4'h2
`define FESR_OP_SECT    4'h3
`define FESR_OP_PROG    4'h4
`define FESR_OP_DIC     4'h5
`define FESR_OP_PPBER   4'h6
`define FESR_OP_EVAL    4'h7
`define FESR_OP_CNT     4'h8
`define FESR_OP_SUSP    4'h9
`define FESR_OP_RES     4'ha
`define FESR_OP_CLR     4'hb
`define FESR_OP_FAIL    4'hc
`define FESR_S1_BUSY    0
`define FESR_S1_WEN     1
`define FESR_S1_ERR     5
`define FESR_S2_PSUS    8
`define FESR_S2_ESUS    9
`define FESR_S2_ESTAT   10
`define FESR_S2_DSUS    12
`define FESR_OX_BUSY    23
`define FESR_OX_ESUS    22
`define FESR_OX_PSUS    18
`define FESR_OX_DSUS    24
`define FESR_PR_BP      2:0
`define FESR_PR_PLCK    3
`define FESR_PR_PPMD    4
`define FESR_PR_PERM    5
`define FESR_CNT_BAD    23
`define FESR_ARG_SECT   31:16
`define FESR_ARG_PAGE   23:8
`define FESR_EES_NS     32'd10000
`define FESR_SEC_NS     32'd5000
`define FESR_PEDS_NS    32'd400
`define FESR_OPS_NS     32'd20000
`define FESR_CLK_NS     32'd10
`endif

// file: logic/fesr_pkg.sv
// Types shared by the controller.
// Assumes fesr_defs.svh is on the include path.
`include "fesr_defs.svh"
package fesr_pkg;
	typedef enum logic [6:0] {
		FESR_IDLE  = 7'h01,
		FESR_PROG  = 7'h02,
		FESR_SECT  = 7'h04,
		FESR_CHIP  = 7'h08,
		FESR_DIC   = 7'h10,
		FESR_EVAL  = 7'h20,
		FESR_CNT   = 7'h40
	} fesr_op_e;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic        busy;
	} fesr_wr_s;
	typedef struct packed {
		fesr_op_e    op;
		logic [31:0] timer;
		logic [31:0] eraseLeft;
		logic [31:0] progLeft;
		logic [31:0] dicLeft;
		logic        progSus;
		logic        eraseSus;
		logic        dicSus;
		logic        progInErase;
		logic        wen;
		logic        eraseErr;
		logic        progErr;
		logic        eraseStat;
		logic [23:0] count;
		logic [7:0]  prot;
		logic [31:0] arg;
		logic [15:0] eraseSector;
		logic [15:0] progPage;
		logic        awOk;
		logic [7:0]  awAddr;
		logic        wOk;
		logic [31:0] wData;
		logic        bValid;
		logic [1:0]  bResp;
		logic        arReady;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic        ppbAllOnes;
		logic [2:0]  sclkSync;
		logic        sclkSeen;
		logic [15:0] sclkEdges;
		logic        awRdy;
		logic        wRdy;
		logic        busyOut;
		logic        undefOut;
	} fesr_state_s;
endpackage

// file: sim/fesr_link_host.sv
// Host side of the link: makes the link clock for one frame per request.
// Assumes the bench pulses go for one clock cycle and waits for the frame.
`timescale 1ns/1ns
module fesr_link_host #(
	parameter int PERIODS = 4
) (
	// Frame request.
	input  wire logic go,
	// Link clock to the device.
	output logic      linkClk
);
	// The clock stands low between frames, as a real host leaves it.
	initial linkClk = 1'b0;
	always @(posedge go) begin
		repeat (PERIODS) begin
			#40 linkClk = 1'b1;
			#40 linkClk = 1'b0;
		end
	end
endmodule

// file: sim/tb.sv
// Self-checking bench of the erase, suspend and resume controller.
// Assumes fesr_defs.svh on the include path and the link host model.
`timescale 1ns/1ns
`include "fesr_defs.svh"
module tb;
	logic        clk, rst_n, go, linkClk;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, busy, undef;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, keep;
	logic [1:0]  bresp, rresp, resp;
	int          num_errors, checked, cyc;

	fesr_link_host link_u (.go(go), .linkClk(linkClk));
	fesr_ctrl #(.OP_CYCLES(20)) dut_u (
		.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.deviceBusy(busy), .undefinedRead(undef));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bt(input int p, input logic e);
		chk({31'h0, rd[p]}, {31'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
	endtask

	task automatic cmd(input logic [3:0] op);
		wr(`FESR_A_CMD, {28'h0, op});
	endtask

	// Polls busy until the operation ends, as the host must.
	task automatic idle(input int lim);
		int n;
		n = 0;
		rdr(`FESR_A_STAT);
		while (rd[`FESR_S1_BUSY] === 1'b1 && n < lim) begin
			rdr(`FESR_A_STAT);
			n++;
		end
		bt(`FESR_S1_BUSY, 1'b0);
		chk({31'h0, busy}, 32'h0);
	endtask

	task automatic done_test(input string name);
		$display("test %s ended, errors %0d", name, num_errors);
	endtask

	task automatic test_done;
		$display("checks %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			test_done;
		end
	end

	initial begin
		{rst_n, go, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Map and refusals.
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b0);
		rdr(8'h18);
		chk({30'h0, resp}, 32'h2);
		wr(8'h1e, 32'h0);
		chk({30'h0, resp}, 32'h2);
		done_test("map");
		// Chip erase under block protection and erase without enable.
		wr(`FESR_A_PROT, 32'h1);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_CHIP);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b0);
		bt(`FESR_S1_ERR, 1'b0);
		wr(`FESR_A_PROT, 32'h0);
		wr(`FESR_A_ARG, 32'h0);
		cmd(`FESR_OP_SECT);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b0);
		done_test("protect");
		// Sector erase, count and erase check.
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_SECT);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b1);
		idle(100);
		bt(`FESR_S1_WEN, 1'b0);
		cmd(`FESR_OP_CNT);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b1);
		idle(400);
		rdr(`FESR_A_COUNT);
		chk(rd, 32'h1);
		cmd(`FESR_OP_EVAL);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b1);
		idle(600);
		bt(`FESR_S2_ESTAT, 1'b1);
		wr(`FESR_A_ARG, 32'h00010000);
		cmd(`FESR_OP_EVAL);
		idle(600);
		bt(`FESR_S2_ESTAT, 1'b0);
		wr(`FESR_A_ARG, 32'h0);
		done_test("status");
		// Erase suspend with a program suspended inside it.
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_SECT);
		cmd(`FESR_OP_SUSP);
		idle(20);
		bt(`FESR_S2_ESUS, 1'b1);
		bt(`FESR_OX_ESUS, 1'b1);
		chk({31'h0, undef}, 32'h1);
		wr(`FESR_A_ARG, 32'h00010000);
		chk({31'h0, undef}, 32'h0);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_PROG);
		idle(100);
		bt(`FESR_S2_ESUS, 1'b1);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_PROG);
		cmd(`FESR_OP_FAIL);
		cmd(`FESR_OP_CLR);
		idle(100);
		bt(`FESR_S2_ESUS, 1'b1);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_PROG);
		cmd(`FESR_OP_SUSP);
		idle(20);
		bt(`FESR_S2_PSUS, 1'b1);
		bt(`FESR_OX_PSUS, 1'b1);
		chk({30'h0, resp}, 32'h0);
		chk({31'h0, undef}, 32'h1);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_SECT);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b0);
		cmd(`FESR_OP_RES);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b1);
		bt(`FESR_S2_PSUS, 1'b0);
		bt(`FESR_S2_ESUS, 1'b1);
		idle(100);
		cmd(`FESR_OP_RES);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b1);
		idle(100);
		bt(`FESR_S2_ESUS, 1'b0);
		done_test("suspend");
		// Chip erase ignores suspend.
		wr(`FESR_A_ARG, 32'h0);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_CHIP);
		cmd(`FESR_OP_SUSP);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b1);
		chk({31'h0, busy}, 32'h1);
		idle(100);
		bt(`FESR_S2_ESUS, 1'b0);
		bt(`FESR_S1_ERR, 1'b0);
		done_test("chip");
		// Integrity check suspend, then idle suspend and resume.
		cmd(`FESR_OP_DIC);
		cmd(`FESR_OP_SUSP);
		repeat (40) @(posedge clk);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_BUSY, 1'b0);
		bt(`FESR_S2_DSUS, 1'b1);
		bt(`FESR_OX_DSUS, 1'b1);
		cmd(`FESR_OP_RES);
		idle(100);
		bt(`FESR_S2_DSUS, 1'b0);
		keep = rd;
		cmd(`FESR_OP_SUSP);
		rdr(`FESR_A_STAT);
		chk(rd, keep);
		cmd(`FESR_OP_RES);
		rdr(`FESR_A_STAT);
		chk(rd, keep);
		done_test("check");
		// Lock erase aborts under the freeze bit, then sets every lock.
		wr(`FESR_A_PROT, 32'h8);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_PPBER);
		rdr(`FESR_A_STAT);
		bt(`FESR_S1_ERR, 1'b1);
		rdr(`FESR_A_PROT);
		bt(8, 1'b0);
		wr(`FESR_A_PROT, 32'h0);
		cmd(`FESR_OP_CLR);
		cmd(`FESR_OP_WREN);
		cmd(`FESR_OP_PPBER);
		idle(100);
		rdr(`FESR_A_PROT);
		bt(8, 1'b1);
		done_test("locks");
		// One link frame of four periods gives eight edges.
		rdr(`FESR_A_RDCHK);
		keep = rd;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (40) @(posedge clk);
		rdr(`FESR_A_RDCHK);
		chk({16'h0, rd[15:0]}, {16'h0, keep[15:0] + 16'h8});
		done_test("link");
		test_done;
	end
endmodule
